// >>> pkg/psfr_map.vh
// Constants for the power stage fault reporting block.
// Assumes a single 50 MHz clock and an active-low reset input pin.
// Overview of operation
// - Half-bridges stay Hi-Z until both supplies are above undervoltage.
// - Reset input low enables weak output pulldown for bootstrap charging, except in single-ended mode.
// - Any shutdown fault drives the fault output low.
// - High temperature warnings go low above 125 C indication.
// - Low temperature warning goes low above 100 C indication.
// - Status outputs follow the fault and warning encoding table.
// - Fault and warning outputs are active-low open-drain.
// - Reset input low forces the fault output released high.
// - A shutdown fault at once sets Hi-Z and asserts the fault output.
// - Faults other than overload and overtemperature recover by themselves.
// - Shutdown groups A+B and C+D, all four in parallel bridge mode.
// - Bootstrap undervoltage shuts down only its own half-bridge.
// - Overtemperature error latches until the reset input is asserted.
// - Overload shutdown clears only on a rising edge of reset input.
// - Warnings hold until temperature falls by the hysteresis amount.
`ifndef PSFR_MAP_VH
`define PSFR_MAP_VH
`define PSFR_MODE_BRIDGE_TIED   2'h0
`define PSFR_MODE_PARALLEL      2'h1
`define PSFR_MODE_SINGLE_ENDED  2'h2
`define PSFR_SYNC_STAGES        2
`define PSFR_NUM_HB             4
`define PSFR_HB_ALL             4'hF
`define PSFR_HB_NONE            4'h0
`endif

// >>> rtl/psfr_sync.v
// Two-flip-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs come from analog comparators or pins.
`timescale 1ns/1ns
`default_nettype none
module psfr_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // psfr_sync
`default_nettype wire

// >>> rtl/psfr_top.v
// Fault supervision and reporting for a four half-bridge power stage.
// Assumes comparator inputs are asynchronous and active high.
`timescale 1ns/1ns
`default_nettype none
`include "psfr_map.vh"
module psfr_top (
    input  wire       REF_CLK,
    input  wire       RSTN,
    input  wire       RESET_IN_N,
    input  wire [1:0] OUTPUT_MODE,
    input  wire [3:0] GATE_DRIVE_SUPPLY_UV,
    input  wire       COMMON_SUPPLY_UV,
    input  wire [3:0] OVERLOAD_DET,
    input  wire [3:0] BOOTSTRAP_PIN_UV,
    input  wire       TEMP_ABOVE_LOW,
    input  wire       TEMP_BELOW_LOW_HYST,
    input  wire       TEMP_ABOVE_HIGH,
    input  wire       TEMP_BELOW_HIGH_HYST,
    input  wire       TEMP_ABOVE_ERROR,
    output reg  [3:0] HB_HIZ,
    output reg  [3:0] HB_PULLDOWN,
    output reg        FAULT_SHUTDOWN_N_OUT,
    output reg        FAULT_SHUTDOWN_N_OE,
    output reg        TEMP_WARN_HIGH_N_OUT,
    output reg        TEMP_WARN_HIGH_N_OE,
    output reg        TEMP_WARN_HIGH2_N_OUT,
    output reg        TEMP_WARN_HIGH2_N_OE,
    output reg        TEMP_WARN_LOW_N_OUT,
    output reg        TEMP_WARN_LOW_N_OE,
    output reg        OVERTEMP_ERROR,
    output reg        OVERLOAD_FAULT
);

    // Synchroniser input bus; the error comparator has a pair of its own.
    wire [19:0] raw_in;
    wire [19:0] s;

    assign raw_in = {RESET_IN_N,
                     OUTPUT_MODE,
                     GATE_DRIVE_SUPPLY_UV,
                     COMMON_SUPPLY_UV,
                     OVERLOAD_DET,
                     BOOTSTRAP_PIN_UV,
                     TEMP_ABOVE_LOW,
                     TEMP_BELOW_LOW_HYST,
                     TEMP_ABOVE_HIGH,
                     TEMP_BELOW_HIGH_HYST};

    // Every comparator and pin level passes two flops before use.
    psfr_sync #(
        .W     (20)
    ) u_sync (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .d     (raw_in),
        .q     (s)
    );

    wire       rst_in_n  = s[19];
    wire [1:0] mode      = s[18:17];
    wire [3:0] gd_uv     = s[16:13];
    wire       com_uv    = s[12];
    wire [3:0] ovl       = s[11:8];
    wire [3:0] bst_uv    = s[7:4];
    wire       t_low     = s[3];
    wire       t_low_clr = s[2];
    wire       t_high    = s[1];
    wire       t_hi_clr  = s[0];

    // Error comparator synchroniser, status latches and edge detector.
    reg        err_m;
    reg        raw_err_s;
    reg        t_err;
    reg        rst_in_q;
    reg        warn_low;
    reg        warn_high;
    reg  [3:0] ovl_latch;

    // Next values, computed in the combinational processes below.
    reg  [3:0] next_hiz;
    reg  [3:0] next_pulldown;
    reg        next_fault_oe;
    reg        next_overtemp;
    reg        next_overload;
    reg  [3:0] next_ovl_latch;
    reg        next_warn_low;
    reg        next_warn_high;

    // Maps per-half-bridge errors onto the shutdown group for the mode.
    function [3:0] psfr_group;
        input [3:0] err;
        input [1:0] md;
        begin
            if (md == `PSFR_MODE_PARALLEL) begin
                psfr_group = {4{|err}};
            end else begin
                psfr_group = {{2{|err[3:2]}}, {2{|err[1:0]}}};
            end
        end
    endfunction

    wire       uv_any   = com_uv | (|gd_uv);
    wire       rst_rise = rst_in_n & ~rst_in_q;
    wire       ovl_any  = (|ovl_latch) | (|ovl);
    wire [3:0] grp_off  = psfr_group(ovl_latch | ovl, mode);
    wire       shut     = uv_any | OVERTEMP_ERROR | t_err | ovl_any;
    wire       all_off  = ~rst_in_n | uv_any | OVERTEMP_ERROR | t_err;

    // The whole stage goes Hi-Z on reset, undervoltage or overtemperature,
    // a group on overload, and one half-bridge on bootstrap undervoltage.
    always @* begin
        next_hiz = grp_off | bst_uv;
        if (all_off) begin
            next_hiz = `PSFR_HB_ALL;
        end
    end

    // The pulldown charges bootstrap capacitors, never in single-ended mode.
    always @* begin
        next_pulldown = `PSFR_HB_NONE;
        if (!rst_in_n && mode != `PSFR_MODE_SINGLE_ENDED) begin
            next_pulldown = `PSFR_HB_ALL;
        end
    end

    // Reset low releases the fault pin whatever faults are present.
    always @* begin
        next_fault_oe = shut;
        if (!rst_in_n) begin
            next_fault_oe = 1'b0;
        end
    end

    // A new error wins over a reset held low in the same cycle.
    always @* begin
        next_overtemp = OVERTEMP_ERROR;
        if (raw_err_s) begin
            next_overtemp = 1'b1;
        end else if (!rst_in_n) begin
            next_overtemp = 1'b0;
        end
    end

    // Overload stays latched until the reset input rises.
    always @* begin
        next_ovl_latch = ovl_latch | ovl;
        next_overload  = OVERLOAD_FAULT | (|ovl);
        if (rst_rise) begin
            next_ovl_latch = ovl;
            next_overload  = |ovl;
        end
    end

    // Warnings set on the threshold and clear only on the hysteresis mark.
    always @* begin
        next_warn_low = warn_low;
        if (t_low) begin
            next_warn_low = 1'b1;
        end else if (t_low_clr) begin
            next_warn_low = 1'b0;
        end
    end

    always @* begin
        next_warn_high = warn_high;
        if (t_high) begin
            next_warn_high = 1'b1;
        end else if (t_hi_clr) begin
            next_warn_high = 1'b0;
        end
    end

    // Two flops for the error comparator before the latch reads it.
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            err_m     <= 1'b0;
            raw_err_s <= 1'b0;
        end else begin
            err_m     <= TEMP_ABOVE_ERROR;
            raw_err_s <= err_m;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            t_err <= 1'b0;
        end else begin
            t_err <= raw_err_s;
        end
    end

    // Starts low like the synchronised pin; a pin held high at reset still gives one rising edge after reset.
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_in_q <= 1'b0;
        end else begin
            rst_in_q <= rst_in_n;
        end
    end

    // Latched status flags.
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            OVERTEMP_ERROR <= 1'b0;
        end else begin
            OVERTEMP_ERROR <= next_overtemp;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            OVERLOAD_FAULT <= 1'b0;
        end else begin
            OVERLOAD_FAULT <= next_overload;
        end
    end

    // Per-half-bridge overload memory for the shutdown grouping.
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ovl_latch <= `PSFR_HB_NONE;
        end else begin
            ovl_latch <= next_ovl_latch;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            warn_low <= 1'b0;
        end else begin
            warn_low <= next_warn_low;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            warn_high <= 1'b0;
        end else begin
            warn_high <= next_warn_high;
        end
    end

    // Half-bridge controls.
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            HB_HIZ <= `PSFR_HB_ALL;
        end else begin
            HB_HIZ <= next_hiz;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            HB_PULLDOWN <= `PSFR_HB_NONE;
        end else begin
            HB_PULLDOWN <= next_pulldown;
        end
    end

    // Open-drain pins: the value is always low, the enable pulls the line.
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            FAULT_SHUTDOWN_N_OUT <= 1'b0;
            FAULT_SHUTDOWN_N_OE  <= 1'b0;
        end else begin
            FAULT_SHUTDOWN_N_OUT <= 1'b0;
            FAULT_SHUTDOWN_N_OE  <= next_fault_oe;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            TEMP_WARN_HIGH_N_OUT <= 1'b0;
            TEMP_WARN_HIGH_N_OE  <= 1'b0;
        end else begin
            TEMP_WARN_HIGH_N_OUT <= 1'b0;
            TEMP_WARN_HIGH_N_OE  <= warn_high | t_high;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            TEMP_WARN_HIGH2_N_OUT <= 1'b0;
            TEMP_WARN_HIGH2_N_OE  <= 1'b0;
        end else begin
            TEMP_WARN_HIGH2_N_OUT <= 1'b0;
            TEMP_WARN_HIGH2_N_OE  <= warn_high | t_high;
        end
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            TEMP_WARN_LOW_N_OUT <= 1'b0;
            TEMP_WARN_LOW_N_OE  <= 1'b0;
        end else begin
            TEMP_WARN_LOW_N_OUT <= 1'b0;
            TEMP_WARN_LOW_N_OE  <= warn_low | t_low;
        end
    end
endmodule // psfr_top
`default_nettype wire

// >>> bench/psfr_props.sv
// Pin checks for the fault reporting block.
// Bound into psfr_top; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module psfr_props (
    input wire logic       REF_CLK, RSTN, RESET_IN_N,
    input wire logic       COMMON_SUPPLY_UV, TEMP_ABOVE_HIGH,
    input wire logic [1:0] OUTPUT_MODE,
    input wire logic [3:0] HB_HIZ, HB_PULLDOWN,
    input wire logic       FAULT_SHUTDOWN_N_OE, TEMP_WARN_HIGH_N_OE,
    input wire logic       OVERTEMP_ERROR, OVERLOAD_FAULT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    a_supply_hiz: assert property (COMMON_SUPPLY_UV[*6] |->
        HB_HIZ == 4'hF) else $error("no Hi-Z on low supply");
    a_fault_low: assert property ((RESET_IN_N && COMMON_SUPPLY_UV)[*6]
        |-> FAULT_SHUTDOWN_N_OE) else $error("fault pin released");
    a_reset_release: assert property (!RESET_IN_N[*6] |->
        !FAULT_SHUTDOWN_N_OE && HB_HIZ == 4'hF) else $error("reset pins");
    a_reset_pull: assert property (
        (!RESET_IN_N && OUTPUT_MODE != 2'h2)[*6] |-> HB_PULLDOWN == 4'hF)
        else $error("pulldown off");
    a_warn_high: assert property (TEMP_ABOVE_HIGH[*6] |->
        TEMP_WARN_HIGH_N_OE) else $error("high warning missing");
    a_overload_hold: assert property (
        RESET_IN_N[*4] ##0 OVERLOAD_FAULT |=> OVERLOAD_FAULT)
        else $error("overload cleared");
    a_overtemp_hold: assert property (
        RESET_IN_N[*4] ##0 OVERTEMP_ERROR |=> OVERTEMP_ERROR)
        else $error("overtemp cleared");
    a_overtemp_hiz: assert property (OVERTEMP_ERROR[*2] |->
        HB_HIZ == 4'hF) else $error("overtemp not Hi-Z");
endmodule // psfr_props
bind psfr_top psfr_props psfr_props_inst (.REF_CLK, .RSTN, .RESET_IN_N,
    .COMMON_SUPPLY_UV, .TEMP_ABOVE_HIGH, .OUTPUT_MODE, .HB_HIZ, .HB_PULLDOWN,
    .FAULT_SHUTDOWN_N_OE, .TEMP_WARN_HIGH_N_OE, .OVERTEMP_ERROR,
    .OVERLOAD_FAULT);
`default_nettype wire

// >>> bench/psfr_ctrl_model.sv
// Controller model driving the device reset pin.
// Assumes the fault pin enable is sampled on the block clock.
`timescale 1ns/1ns
`default_nettype none
module psfr_ctrl_model #(
    parameter int HOLD = 200000
) (
    input  wire logic clk,
    input  wire logic fault_oe,
    input  wire logic req,
    output var  logic reset_n
);
    int since = HOLD;
    initial reset_n = 1'b0;
    // The pin rises only once the fault has been low long enough.
    always @(posedge clk) begin
        since <= $rose(fault_oe) ? 0 : since + 1;
        reset_n <= !req && (reset_n || since >= HOLD);
    end
endmodule // psfr_ctrl_model
`default_nettype wire

// >>> bench/psfr_top_tb.sv
// Testbench for the fault reporting block.
// Inputs change at falling edges; a model drives the reset pin.
`timescale 1ns/1ns
`default_nettype none
module psfr_top_tb;
    logic clk = 0, rstn = 0, req = 1, cu = 0, tl = 0, tlh = 1, th = 0;
    logic thh = 1, te = 0, rin, sd, wh, wh2, wl, overtemp_error, overload_fault;
    logic fo, ho, h2o, lo;
    logic [1:0] mode = 2'h0;
    logic [3:0] gu = 4'h0, ovl = 4'h0, bu = 4'h0, hiz, pd;
    int mismatches = 0, n_tests = 0, cyc = 0;
    psfr_top psfr_top_inst (.REF_CLK(clk), .RSTN(rstn), .RESET_IN_N(rin),
        .OUTPUT_MODE(mode), .GATE_DRIVE_SUPPLY_UV(gu), .COMMON_SUPPLY_UV(cu),
        .OVERLOAD_DET(ovl), .BOOTSTRAP_PIN_UV(bu), .TEMP_ABOVE_LOW(tl),
        .TEMP_BELOW_LOW_HYST(tlh), .TEMP_ABOVE_HIGH(th),
        .TEMP_BELOW_HIGH_HYST(thh), .TEMP_ABOVE_ERROR(te), .HB_HIZ(hiz),
        .HB_PULLDOWN(pd), .FAULT_SHUTDOWN_N_OUT(fo), .FAULT_SHUTDOWN_N_OE(sd),
        .TEMP_WARN_HIGH_N_OUT(ho), .TEMP_WARN_HIGH_N_OE(wh),
        .TEMP_WARN_HIGH2_N_OUT(h2o), .TEMP_WARN_HIGH2_N_OE(wh2),
        .TEMP_WARN_LOW_N_OUT(lo), .TEMP_WARN_LOW_N_OE(wl),
        .OVERTEMP_ERROR(overtemp_error), .OVERLOAD_FAULT(overload_fault));
    psfr_ctrl_model #(.HOLD(20)) psfr_ctrl_model_inst (.clk(clk),
        .fault_oe(sd), .req(req), .reset_n(rin));
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin
        mismatches++;
        finish_test();
    end
    task automatic chk(input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse;
        req = 1;
        wt(6);
        req = 0;
        wt(30);
    endtask
    task automatic t_supply;
        cu = 1;
        for (int m = 0; m < 3; m++) begin
            mode = m[1:0];
            wt(8);
            chk({sd, pd, hiz[0]},
                {1'b0, m == 2 ? 4'h0 : 4'hF, 1'b1});
        end
        mode = 2'h0;
        req = 0;
        wt(30);
        chk({sd, hiz}, 5'h1F);
        cu = 0;
        gu = 4'h4;
        wt(8);
        chk({sd, hiz}, 5'h1F);
        gu = 4'h0;
        wt(8);
        chk({sd, hiz}, 5'h00);
    endtask
    task automatic t_overload;
        for (int i = 0; i < 12; i++) begin
            mode = i[3:2];
            ovl = 4'h1 << i[1:0];
            wt(6);
            ovl = 4'h0;
            wt(6);
            chk({overload_fault, sd, hiz},
                {2'h3, mode == 2'h1 ? 4'hF : i[1] ? 4'hC : 4'h3});
            pulse();
            chk({overload_fault, sd, hiz}, 6'h00);
        end
    endtask
    task automatic t_boot;
        mode = 2'h1;
        for (int i = 0; i < 5; i++) begin
            bu = i < 4 ? 4'h1 << i : 4'h0;
            wt(8);
            chk(hiz, bu);
        end
    endtask
    task automatic t_temp;
        {tl, tlh} = 2'h2;
        wt(8);
        chk({sd, wl, wh, wh2}, 4'h4);
        {th, thh} = 2'h2;
        wt(8);
        chk({sd, wl, wh, wh2}, 4'h7);
        chk({fo, ho, h2o, lo}, 4'h0);
        {tl, th} = 2'h0;
        wt(8);
        chk({sd, wl, wh, wh2}, 4'h7);
        {tlh, thh} = 2'h3;
        wt(8);
        chk({sd, wl, wh, wh2}, 4'h0);
        te = 1;
        wt(6);
        te = 0;
        wt(6);
        chk({overtemp_error, sd, hiz}, 6'h3F);
        pulse();
        chk({overtemp_error, sd, hiz}, 6'h00);
    endtask
    task automatic finish_test;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        wt(3);
        rstn = 1;
        t_supply();
        t_overload();
        t_boot();
        t_temp();
        finish_test();
    end
endmodule // psfr_top_tb
`default_nettype wire
